// ---- verilog/qsf_defs.svh ----
// Purpose: Shared constants for the quad serial flash data pin block.
// Assumes: Included by bare name from the package and the design file.
// Notes:   Definitions only.
`ifndef QSF_DEFS_SVH
`define QSF_DEFS_SVH
`define QSF_BYTE_BITS   8
`define QSF_HDR_W       8
`define QSF_CNT_W       4
`define QSF_LANE_COUNT  4
`define QSF_BYTE_LAST   4'h8
`define QSF_HDR_MAX     8'hff
`define QSF_OE_NONE     4'h0
`define QSF_OE_SINGLE   4'h2
`define QSF_OE_DUAL     4'h3
`define QSF_OE_QUAD     4'hf
`endif

// ---- verilog/qsf_pkg.sv ----
// Purpose: Types for the quad serial flash data pin block.
// Assumes: Constants come from qsf_defs.svh.
// Notes:   Nothing is imported; users write qsf_pkg::name.
`include "qsf_defs.svh"
package qsf_pkg;
	typedef enum logic [1:0] {QSF_SINGLE, QSF_DUAL, QSF_QUAD} qsf_lane_t;
	typedef struct packed {
		qsf_lane_t                 lanes;
		logic                      read;
		logic [`QSF_HDR_W-1:0]     hdr_bits;
	} qsf_op_t;
	typedef struct packed {
		logic [`QSF_LANE_COUNT-1:0] out;
		logic [`QSF_LANE_COUNT-1:0] oe;
	} qsf_pins_t;
endpackage : qsf_pkg

// ---- verilog/qsf_data_pins.sv ----
// Purpose: Direction and edge control of the four serial data lines of a flash device.
// Assumes: The host makes host_serial_clock and serial_cs_n; core_clk is the device core clock.
// Notes:   Operation setup must be stable before the frame and for all of it.
//
// Overview of operation
// (RULE1) Single-lane mode receives write data on line zero at rising clock edges.
// (RULE2) Four-lane mode: line zero receives on rising edges, drives on falling edges.
// (RULE3) Read data leaves on line one in both modes, changing at falling edges.
// (RULE4) Dual and quad fast writes sample lines zero and one on rising edges.
// (RULE5) Dual and quad fast reads drive lines zero and one at falling edges.
// (RULE6) Four-lane mode reads drive line two, changing on falling edges.
// (RULE7) Quad fast write samples line two rising; quad fast read drives it falling.
// (RULE8) The host holds chip select low throughout each operation.
// (RULE9) With chip select high every data line is released.
// (RULE10) After power-up the host gives a chip select falling edge first; the host model gives two serial clock pulses with chip select high before it.
// (RULE11) The host makes the serial clock and captures on the next falling edge.
// (RULE12) Lines are driven only in the output phase of a read operation.
`timescale 1ns/1ps
`include "qsf_defs.svh"
module qsf_data_pins (
	input  wire logic                          core_clk,
	input  wire logic                          rst_n,
	input  wire logic                          host_serial_clock,
	input  wire logic                          serial_cs_n,
	input  wire logic [`QSF_LANE_COUNT-1:0]    serial_io_in,
	output logic      [`QSF_LANE_COUNT-1:0]    serial_io_out,
	output logic      [`QSF_LANE_COUNT-1:0]    serial_io_oe,
	input  wire qsf_pkg::qsf_op_t              op_cfg,
	input  wire logic [`QSF_BYTE_BITS-1:0]     tx_data,
	output logic                               tx_taken,
	output logic      [`QSF_BYTE_BITS-1:0]     rx_data,
	output logic                               rx_valid
);
	function automatic logic [`QSF_CNT_W-1:0] qsf_width(input qsf_pkg::qsf_lane_t l);
		unique case (l)
			qsf_pkg::QSF_SINGLE: qsf_width = 4'h1;
			qsf_pkg::QSF_DUAL:   qsf_width = 4'h2;
			qsf_pkg::QSF_QUAD:   qsf_width = 4'h4;
			default:             qsf_width = 4'h1;
		endcase
	endfunction : qsf_width

	// Chip select high ends a frame at once, without waiting for a clock edge.
	wire logic frame_rst_n = rst_n & ~serial_cs_n; // RULE9

	// Link-side copy of the setup; stable by contract, so two flops suffice.
	// A change of op_cfg inside a frame reaches op_l two link edges later; the core must keep the setup time.
	qsf_pkg::qsf_op_t op_s1;
	qsf_pkg::qsf_op_t op_l;
	always_ff @(posedge host_serial_clock or negedge rst_n) begin
		if (!rst_n) begin
			op_s1 <= '0;
			op_l  <= '0;
		end else begin
			op_s1 <= op_cfg;
			op_l  <= op_s1;
		end
	end

	// Rising-edge side: count header bits and shift in write data.
	// Bits of a byte still open at deselect are dropped, never handed to the core.
	logic [`QSF_HDR_W-1:0]     hdr_cnt;
	logic [`QSF_BYTE_BITS-1:0] rx_sh;
	logic [`QSF_CNT_W-1:0]     rx_cnt;
	logic                      out_phase;
	wire logic                     hdr_done   = hdr_cnt >= op_l.hdr_bits;
	wire logic                     rx_enable  = !(hdr_done && op_l.read); // RULE12
	wire logic [`QSF_CNT_W-1:0]    rx_w       = hdr_done ? qsf_width(op_l.lanes) : 4'h1; // RULE1
	wire logic [`QSF_CNT_W-1:0]    next_rx_cnt = rx_cnt + rx_w;
	wire logic                     byte_done  = rx_enable && next_rx_cnt == `QSF_BYTE_LAST;
	logic [`QSF_BYTE_BITS-1:0]     next_rx_sh;
	always_comb begin
		unique case (rx_w)
			4'h2:    next_rx_sh = {rx_sh[5:0], serial_io_in[1:0]}; // RULE4
			4'h4:    next_rx_sh = {rx_sh[3:0], serial_io_in[3:0]}; // RULE7
			default: next_rx_sh = {rx_sh[6:0], serial_io_in[0]}; // RULE1
		endcase
	end

	always_ff @(posedge host_serial_clock or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			hdr_cnt   <= '0;
			rx_sh     <= '0;
			rx_cnt    <= '0;
			out_phase <= 1'b0;
		end else begin
			if (!hdr_done)
				hdr_cnt <= hdr_cnt + 8'h01;
			if (rx_enable) begin
				rx_sh  <= next_rx_sh;
				rx_cnt <= byte_done ? 4'h0 : next_rx_cnt;
			end
			out_phase <= op_l.read && (hdr_cnt + 8'h01 >= op_l.hdr_bits || hdr_done); // RULE12
		end
	end

	// Finished bytes cross to the core by a toggle; the byte holds two link clocks at least.
	logic [`QSF_BYTE_BITS-1:0] rx_byte;
	logic                      rx_tog;
	always_ff @(posedge host_serial_clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_byte <= '0;
			rx_tog  <= 1'b0;
		end else if (frame_rst_n && byte_done) begin
			rx_byte <= next_rx_sh;
			rx_tog  <= ~rx_tog;
		end
	end

	// Falling-edge side: shift read data out, most significant bit first.
	// A frame cut in mid-byte loses the rest of it; the next read starts on tx_hold.
	logic [`QSF_BYTE_BITS-1:0] tx_hold;
	logic [`QSF_BYTE_BITS-1:0] tx_sh;
	logic [`QSF_CNT_W-1:0]     tx_cnt;
	wire logic [`QSF_CNT_W-1:0]    tx_w       = qsf_width(op_l.lanes);
	wire logic                     tx_load    = out_phase && tx_cnt == 4'h0;
	wire logic [`QSF_BYTE_BITS-1:0] tx_src    = tx_load ? tx_hold : tx_sh;
	wire logic [`QSF_CNT_W-1:0]    next_tx_cnt = tx_cnt + tx_w;
	qsf_pkg::qsf_pins_t next_pins;
	always_comb begin
		next_pins = '0;
		if (out_phase) begin
			unique case (op_l.lanes)
				qsf_pkg::QSF_DUAL: begin
					next_pins.out = {2'b00, tx_src[7:6]}; // RULE5
					next_pins.oe  = `QSF_OE_DUAL;
				end
				qsf_pkg::QSF_QUAD: begin
					next_pins.out = tx_src[7:4]; // RULE2 RULE6 RULE7
					next_pins.oe  = `QSF_OE_QUAD;
				end
				default: begin
					next_pins.out = {2'b00, tx_src[7], 1'b0}; // RULE3
					next_pins.oe  = `QSF_OE_SINGLE;
				end
			endcase
		end
	end

	always_ff @(negedge host_serial_clock or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			serial_io_out <= '0;
			serial_io_oe  <= `QSF_OE_NONE; // RULE9
			tx_sh         <= '0;
			tx_cnt        <= '0;
		end else begin
			serial_io_out <= next_pins.out;
			serial_io_oe  <= next_pins.oe; // RULE12
			if (out_phase) begin
				tx_sh  <= tx_src << tx_w;
				tx_cnt <= next_tx_cnt == `QSF_BYTE_LAST ? 4'h0 : next_tx_cnt;
			end
		end
	end

	logic tx_tog;
	always_ff @(negedge host_serial_clock or negedge rst_n) begin
		if (!rst_n)
			tx_tog <= 1'b0;
		else if (frame_rst_n && tx_load)
			tx_tog <= ~tx_tog;
	end

	// Core side: the first flop of each synchroniser feeds only the second.
	logic rx_s1, rx_s2, rx_s3;
	logic tx_s1, tx_s2, tx_s3;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			{rx_s1, rx_s2, rx_s3} <= 3'h0;
			{tx_s1, tx_s2, tx_s3} <= 3'h0;
			rx_valid <= 1'b0;
			rx_data  <= '0;
			tx_taken <= 1'b0;
			tx_hold  <= '0;
		end else begin
			{rx_s1, rx_s2, rx_s3} <= {rx_tog, rx_s1, rx_s2};
			{tx_s1, tx_s2, tx_s3} <= {tx_tog, tx_s1, tx_s2};
			rx_valid <= rx_s2 ^ rx_s3;
			if (rx_s2 ^ rx_s3)
				rx_data <= rx_byte;
			// The next byte must land before the link's next load, at least two link clocks away.
			tx_taken <= tx_s2 ^ tx_s3;
			if (tx_s2 ^ tx_s3)
				tx_hold <= tx_data;
		end
	end

	// Link checks sample at rising edges, half a link clock after the outputs last moved.
	a_header_no_drive: assert property (@(posedge host_serial_clock) // RULE12
		disable iff (!frame_rst_n) !out_phase |-> serial_io_oe == `QSF_OE_NONE)
		else $error("Line driven outside output phase.");
	a_desel_release: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE9
		serial_cs_n |-> serial_io_oe == `QSF_OE_NONE) else $error("Line driven while deselected.");
	a_desel_out_low: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE9
		serial_cs_n |-> serial_io_out == 4'h0) else $error("Line value held while deselected.");
	a_single_line_one: assert property (@(posedge host_serial_clock) // RULE3
		disable iff (!frame_rst_n)
		serial_io_oe != 4'h0 && op_l.lanes == qsf_pkg::QSF_SINGLE |-> serial_io_oe == 4'h2)
		else $error("Single lane read not on line one.");
	a_dual_two_lines: assert property (@(posedge host_serial_clock) // RULE5
		disable iff (!frame_rst_n)
		serial_io_oe != 4'h0 && op_l.lanes == qsf_pkg::QSF_DUAL |-> serial_io_oe == 4'h3)
		else $error("Dual read not on lines zero and one.");
	a_quad_four_lines: assert property (@(posedge host_serial_clock) // RULE6
		disable iff (!frame_rst_n)
		serial_io_oe != 4'h0 && op_l.lanes == qsf_pkg::QSF_QUAD |-> serial_io_oe == 4'hf)
		else $error("Quad read not on all four lines.");
	a_drive_only_read: assert property (@(posedge host_serial_clock) // RULE12
		disable iff (!frame_rst_n) serial_io_oe != 4'h0 |-> op_l.read)
		else $error("Lines driven during a write.");
	a_header_one_bit: assert property (@(posedge host_serial_clock) // RULE1
		disable iff (!frame_rst_n) !hdr_done && rx_cnt < 4'h7 |=> rx_cnt == $past(rx_cnt) + 4'h1)
		else $error("Header not taken one bit per rising edge.");
	a_quad_write_step: assert property (@(posedge host_serial_clock) // RULE4
		disable iff (!frame_rst_n)
		hdr_done && !op_l.read && op_l.lanes == qsf_pkg::QSF_QUAD && rx_cnt == 4'h0
		|=> rx_cnt == 4'h4 ##1 rx_cnt == 4'h0) else $error("Quad write not four bits per edge.");
	a_dual_write_step: assert property (@(posedge host_serial_clock) // RULE4
		disable iff (!frame_rst_n)
		hdr_done && !op_l.read && op_l.lanes == qsf_pkg::QSF_DUAL && rx_cnt == 4'h0
		|=> rx_cnt == 4'h2 ##1 rx_cnt == 4'h4) else $error("Dual write not two bits per edge.");
	a_read_rx_frozen: assert property (@(posedge host_serial_clock) // RULE2
		disable iff (!frame_rst_n) hdr_done && op_l.read |=> $stable(rx_cnt) && $stable(rx_sh))
		else $error("Receive shifter moved during a read.");
	a_rx_handoff: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE1
		rx_s2 != rx_s3 |=> rx_valid ##1 !rx_valid) else $error("Received byte not handed over once.");
	a_tx_handoff: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE3
		tx_s2 != tx_s3 |=> tx_taken ##1 !tx_taken) else $error("Read byte not taken once.");
endmodule : qsf_data_pins

// ---- dv/qsf_host_model.sv ----
// Purpose: Host that clocks whole frames into the data pin block.
// Assumes: The link clock stands still between frames but for two setup edges; period 160 ns.
// Notes:   Released lines show the inverse of the last host drive.
`timescale 1ns/1ps
module qsf_host_model (
	output logic            sclk,
	output logic            cs_n,
	output logic [3:0]      io_in,
	input  wire logic [3:0] dev_out,
	input  wire logic [3:0] dev_oe
);
	logic [3:0] drv;
	logic [3:0] hoe;
	logic [3:0] hdr_oe;
	logic [3:0] seen_oe;
	assign io_in = (dev_oe & dev_out) | (~dev_oe & ((hoe & drv) | (~hoe & ~drv)));
	initial begin
		{sclk, cs_n, drv, hoe} = 10'h100;
	end
	task automatic frame(input int w, input logic rd, input logic [7:0] wb,
		output logic [7:0] rb);
		logic [23:0] sh;
		int          k;
		sh = {8'h3c, wb, wb};
		rb = 8'h00;
		hdr_oe = 4'h0;
		seen_oe = 4'h0;
		// An odd start offset keeps the link edges apart from the core clock edges.
		#3;
		// Two edges with the chip deselected let the setup cross into the link domain.
		repeat (2) begin
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
		end
		cs_n = 1'b0;
		for (int n = 0; n < 8 + 16 / w; n++) begin
			k = (n < 8) ? 1 : w;
			hoe = (rd && n >= 8) ? 4'h0 : 4'((1 << k) - 1);
			drv = 4'(sh[23 -: 4] >> (4 - k));
			sh = sh << k;
			#80 sclk = 1'b1;
			#79;
			if (n >= 8) seen_oe = seen_oe | dev_oe;
			else hdr_oe = hdr_oe | dev_oe;
			rb = 8'((rb << k) | ((k == 1) ? 4'(io_in[1]) : (io_in & 4'((1 << k) - 1))));
			#1 sclk = 1'b0;
		end
		#80 cs_n = 1'b1;
		hoe = 4'h0;
	endtask : frame
endmodule : qsf_host_model

// ---- dv/qsf_data_pins_bench.sv ----
// Purpose: Self-checking bench for the data pin block.
// Assumes: The host model makes every frame; the opcode field is 8 bits long.
// Notes:   Only the last read byte is judged, as the first follows the prior take.
`timescale 1ns/1ps
`include "qsf_defs.svh"
module qsf_data_pins_bench;
	logic             core_clk;
	logic             rst_n;
	logic             sclk;
	logic             cs_n;
	logic [3:0]       io_in;
	logic [3:0]       io_out;
	logic [3:0]       io_oe;
	qsf_pkg::qsf_op_t op_cfg;
	logic [7:0]       tx_data;
	logic             tx_taken;
	logic [7:0]       rx_data;
	logic             rx_valid;
	logic [7:0]       rx_q[$];
	int               fail_count;
	int               checks;
	int               takes;
	qsf_data_pins qsf_data_pins_inst (.core_clk(core_clk), .rst_n(rst_n),
		.host_serial_clock(sclk), .serial_cs_n(cs_n), .serial_io_in(io_in),
		.serial_io_out(io_out), .serial_io_oe(io_oe), .op_cfg(op_cfg),
		.tx_data(tx_data), .tx_taken(tx_taken), .rx_data(rx_data), .rx_valid(rx_valid));
	qsf_host_model qsf_host_model_inst (.sclk(sclk), .cs_n(cs_n), .io_in(io_in),
		.dev_out(io_out), .dev_oe(io_oe));
	always @(posedge core_clk) if (rx_valid === 1'b1) rx_q.push_back(rx_data);
	always @(posedge core_clk) if (tx_taken === 1'b1) takes++;
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : cmp_byte
	task automatic cmp_mask(input logic [3:0] got, input logic [3:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : cmp_mask
	task automatic run(input qsf_pkg::qsf_lane_t ln, input logic rd, input logic [7:0] wb);
		logic [7:0] rb;
		logic [3:0] em;
		int         w;
		w = (ln == qsf_pkg::QSF_QUAD) ? 4 : (ln == qsf_pkg::QSF_DUAL) ? 2 : 1;
		em = (w == 4) ? `QSF_OE_QUAD : (w == 2) ? `QSF_OE_DUAL : `QSF_OE_SINGLE;
		@(posedge core_clk);
		op_cfg <= '{ln, rd, 8'h08};
		rx_q.delete();
		takes = 0;
		@(posedge core_clk);
		qsf_host_model_inst.frame(w, rd, wb, rb);
		#20;
		cmp_mask(io_oe, `QSF_OE_NONE, "oe after deselect");
		cmp_mask(qsf_host_model_inst.hdr_oe, `QSF_OE_NONE, "oe in header");
		cmp_mask(qsf_host_model_inst.seen_oe, rd ? em : `QSF_OE_NONE, "oe in data");
		repeat (10) @(posedge core_clk);
		cmp_byte(8'(rx_q.size()), rd ? 8'h01 : 8'h03, "bytes received");
		// Two read bytes go out and the closing falling edge starts a third.
		cmp_byte(8'(takes), rd ? 8'h03 : 8'h00, "bytes taken");
		cmp_byte(rx_q[0], 8'h3c, "opcode");
		if (rd) cmp_byte(rb, tx_data, "read byte");
		else cmp_byte(rx_q[2], wb, "write byte");
		$display("test done lanes %0d read %0b", w, rd);
	endtask : run
	task automatic t_single;
		run(qsf_pkg::QSF_SINGLE, 1'b0, 8'ha5);
		run(qsf_pkg::QSF_SINGLE, 1'b1, 8'h00);
	endtask : t_single
	task automatic t_dual;
		run(qsf_pkg::QSF_DUAL, 1'b0, 8'h96);
		run(qsf_pkg::QSF_DUAL, 1'b1, 8'h00);
	endtask : t_dual
	task automatic t_quad;
		run(qsf_pkg::QSF_QUAD, 1'b0, 8'h5a);
		run(qsf_pkg::QSF_QUAD, 1'b1, 8'h00);
	endtask : t_quad
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : conclude
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		rst_n = 1'b0;
		op_cfg = '0;
		tx_data = 8'hc3;
		fail_count = 0;
		checks = 0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		t_single();
		t_dual();
		t_quad();
		conclude();
	end
	// Six frames take about 20 us, so 100 us leaves ample margin.
	initial begin
		#100000;
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		conclude();
	end
endmodule : qsf_data_pins_bench
